// *** hdl/bcid_pkg.sv ***
package bcid_pkg;

   // configuration space byte offsets of the four registers
   localparam logic [11:0] VENDOR_OFS  = 12'h000;
   localparam logic [11:0] DEVICE_OFS  = 12'h002;
   localparam logic [11:0] COMMAND_OFS = 12'h004;
   localparam logic [11:0] STATUS_OFS  = 12'h006;

   // dword indices seen on the configuration port
   localparam logic [9:0]  DW_ID  = VENDOR_OFS[11:2];
   localparam logic [9:0]  DW_CMD = COMMAND_OFS[11:2];

   // command register bit positions
   localparam int unsigned CMD_SUPPRESS_BIT = 10;
   localparam int unsigned CMD_BTOB_BIT     = 9;
   localparam int unsigned CMD_SERR_EN_BIT  = 8;
   localparam int unsigned CMD_RSVD7_BIT    = 7;
   localparam int unsigned CMD_PERR_EN_BIT  = 6;
   localparam int unsigned CMD_SNOOP_BIT    = 5;

   // only bits 10, 8 and 6 hold state; all others read zero
   localparam logic [15:0] CMD_WR_MASK = 16'h0540;
   localparam logic [15:0] CMD_RESET   = 16'h0000;

   // status register: fixed capability-list bit plus two sticky flags
   localparam logic [15:0] STS_FIXED    = 16'h0010;
   localparam int unsigned STS_SSE_BIT  = 14;
   localparam int unsigned STS_MDPE_BIT = 8;
   localparam int unsigned STS_WORD_LSB = 16;

   // one configuration cycle, dword addressed with byte enables
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [9:0]  dw;
      logic [3:0]  be;
      logic [31:0] wdata;
   } bcid_cfg_req_s;

   // upstream message kinds toward the hub
   typedef enum logic [2:0] {
      BCID_MSG_SERR      = 3'h0,
      BCID_MSG_OWN_ASRT  = 3'h1,
      BCID_MSG_OWN_DASRT = 3'h2,
      BCID_MSG_FWD_ASRT  = 3'h3,
      BCID_MSG_FWD_DASRT = 3'h4
   } bcid_msg_kind_e;

   // one upstream message; line is the forwarded interrupt wire a..d
   typedef struct packed {
      bcid_msg_kind_e kind;
      logic [1:0]     line;
   } bcid_msg_s;

   // own legacy interrupt state, gray along idle-req-held-release
   typedef enum logic [1:0] {
      BCID_IRQ_IDLE  = 2'b00,
      BCID_IRQ_AREQ  = 2'b01,
      BCID_IRQ_HELD  = 2'b11,
      BCID_IRQ_DREQ  = 2'b10
   } bcid_irq_state_e;

endpackage

// *** hdl/bcid_own_irq.sv ***
`timescale 1ns/1ps
// tracks the function's own emulated interrupt wire
module bcid_own_irq (
   input  wire logic i_ref_clk,
   input  wire logic i_rst_n,
   input  wire logic i_ce,
   input  wire logic i_req,        // pme or hot-plug cause pending
   input  wire logic i_suppress,   // command bit 10
   input  wire logic i_grant,      // arbiter took our message
   output logic      o_send,       // message wanted
   output logic      o_is_assert,  // 1 assert, 0 deassert
   output logic      o_asserted_r  // wire is currently asserted upstream
);

   bcid_pkg::bcid_irq_state_e state_r;   // message sequencing state

   // a request is withdrawn if cause vanishes before it is granted
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= bcid_pkg::BCID_IRQ_IDLE;
      end else if (i_ce) begin
         case (state_r)
            bcid_pkg::BCID_IRQ_IDLE: begin
               // only raise while not suppressed
               if (i_req && !i_suppress) begin
                  state_r <= bcid_pkg::BCID_IRQ_AREQ;
               end
            end
            bcid_pkg::BCID_IRQ_AREQ: begin
               if (i_grant) begin
                  state_r <= bcid_pkg::BCID_IRQ_HELD;
               end else if (i_suppress || !i_req) begin
                  state_r <= bcid_pkg::BCID_IRQ_IDLE;
               end
            end
            bcid_pkg::BCID_IRQ_HELD: begin
               // suppress forces the release of an asserted wire
               if (i_suppress || !i_req) begin
                  state_r <= bcid_pkg::BCID_IRQ_DREQ;
               end
            end
            bcid_pkg::BCID_IRQ_DREQ: begin
               if (i_grant) begin
                  state_r <= bcid_pkg::BCID_IRQ_IDLE;
               end
            end
            default: begin
               state_r <= bcid_pkg::BCID_IRQ_IDLE;
            end
         endcase
      end
   end

   // upstream view of the wire, follows accepted messages only
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_asserted_r <= 1'b0;
      end else if (i_ce && i_grant) begin
         o_asserted_r <= (state_r == bcid_pkg::BCID_IRQ_AREQ);
      end
   end

   assign o_send      = (state_r == bcid_pkg::BCID_IRQ_AREQ) || (state_r == bcid_pkg::BCID_IRQ_DREQ);
   assign o_is_assert = (state_r == bcid_pkg::BCID_IRQ_AREQ);

endmodule

// *** hdl/bcid_msg_arb.sv ***
`timescale 1ns/1ps
// picks one upstream message per slot: serr, own irq, forwarded
module bcid_msg_arb (
   input  wire logic               i_ref_clk,
   input  wire logic               i_rst_n,
   input  wire logic               i_ce,
   input  wire logic               i_serr_req,
   input  wire logic               i_own_send,
   input  wire logic               i_own_assert,
   input  wire logic               i_fwd_valid,
   input  wire bcid_pkg::bcid_msg_s i_fwd_msg,
   input  wire logic               i_msg_ready,
   output logic                    o_serr_grant,
   output logic                    o_own_grant,
   output logic                    o_fwd_grant,
   output logic                    o_msg_valid_r,
   output bcid_pkg::bcid_msg_s     o_msg_r
);

   logic free;                   // output slot empty or draining
   bcid_pkg::bcid_msg_s pick;    // selected message

   // errors first: a lost serr is worse than a late interrupt
   always_comb begin
      free         = i_ce && (!o_msg_valid_r || i_msg_ready);
      o_serr_grant = free && i_serr_req;
      o_own_grant  = free && !i_serr_req && i_own_send;
      o_fwd_grant  = free && !i_serr_req && !i_own_send && i_fwd_valid;
      pick         = i_fwd_msg;
      if (i_serr_req) begin
         pick.kind = bcid_pkg::BCID_MSG_SERR;
         pick.line = 2'h0;
      end else if (i_own_send) begin
         pick.kind = i_own_assert ? bcid_pkg::BCID_MSG_OWN_ASRT
                                  : bcid_pkg::BCID_MSG_OWN_DASRT;
         pick.line = 2'h0;
      end
   end

   // output register, held until the hub takes it
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_msg_valid_r <= 1'b0;
         o_msg_r       <= '0;
      end else if (free) begin
         o_msg_valid_r <= i_serr_req || i_own_send || i_fwd_valid;
         o_msg_r       <= pick;
      end
   end

endmodule

// *** hdl/bcid_bridge_cfg.sv ***
`timescale 1ns/1ps
module bcid_bridge_cfg #(
   parameter logic [15:0] VENDOR_CODE = 16'h5A5A, // arbitrary value
   parameter logic [7:0]  DEV_UPPER   = 8'hC3,    // arbitrary value
   parameter logic [3:0]  DEV_MIDDLE  = 4'h6,     // arbitrary value
   parameter logic [3:0]  DEV_LOWER   = 4'h9      // arbitrary value
) (
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_rst_n,
   input  wire logic                   i_ce,
   // configuration cycles from the host
   input  wire bcid_pkg::bcid_cfg_req_s i_cfg,
   output logic                        o_cfg_ack,
   output logic [31:0]                 o_cfg_rdata,
   // own interrupt cause (pme / hot-plug), level
   input  wire logic                   i_own_irq_req,
   output logic                        o_own_irq_asserted,
   // forwarded intx messages from the secondary side
   input  wire logic                   i_fwd_intx_valid,
   input  wire logic                   i_fwd_intx_assert,
   input  wire logic [1:0]             i_fwd_intx_line,
   output logic                        o_fwd_intx_ready,
   // primary-side detected errors and device-control enables
   input  wire logic                   i_err_nonfatal,
   input  wire logic                   i_err_fatal,
   input  wire logic                   i_dctl_nonfatal_en,
   input  wire logic                   i_dctl_fatal_en,
   input  wire logic                   i_mstr_parity_err,
   // messages to the io controller hub
   output logic                        o_msg_valid,
   output bcid_pkg::bcid_msg_s         o_msg,
   input  wire logic                   i_msg_ready,
   // command bits for the rest of the bridge
   output logic                        o_legacy_irq_suppress,
   output logic                        o_serr_enable,
   output logic                        o_perr_enable
);

   // ---------------------------------------------------------
   // decoded configuration access
   // ---------------------------------------------------------
   logic        hit_id;         // dword 0: vendor and device code
   logic        hit_cmd;        // dword 1: command and status
   logic        cmd_wr;         // write reaching command/status

   // writable command state; hardwired bits never stored
   logic [15:0] cmd_r;
   logic [15:0] cmd_nxt;

   // sticky status flags
   logic        sts_sse_r;      // signalled system error
   logic        sts_mdpe_r;     // master data parity error
   logic        sse_clr;        // write-one-to-clear strobes
   logic        mdpe_clr;
   logic [15:0] sts_word;       // assembled status read value

   // read-back
   logic [15:0] dev_code;       // device code from its fields
   logic [31:0] rd_mux;

   // error path
   logic        serr_event;     // error that warrants a message
   logic        serr_pend_r;    // waiting for the message slot

   // forwarded message holding slot
   logic        fwd_full_r;
   logic        fwd_full_nxt;
   bcid_pkg::bcid_msg_s fwd_msg_r;

   // arbiter handshakes
   logic        own_send;
   logic        own_assert;
   logic        serr_grant;
   logic        own_grant;
   logic        fwd_grant;

   // command bit views
   logic        suppress;
   logic        serr_en;
   logic        perr_en;

   // dword decode; the port carries no byte address
   assign hit_id  = (i_cfg.dw == bcid_pkg::DW_ID);
   assign hit_cmd = (i_cfg.dw == bcid_pkg::DW_CMD);
   assign cmd_wr  = i_cfg.wr && hit_cmd;

   // named views of the stored command bits
   assign suppress = cmd_r[bcid_pkg::CMD_SUPPRESS_BIT];
   assign serr_en  = cmd_r[bcid_pkg::CMD_SERR_EN_BIT];
   assign perr_en  = cmd_r[bcid_pkg::CMD_PERR_EN_BIT];

   // ---------------------------------------------------------
   // command register
   // ---------------------------------------------------------

   // byte lanes 0 and 1 carry the command; the mask keeps
   // hardwired and reserved bits at zero whatever is written
   // status lanes 2 and 3 never reach it
   always_comb begin
      cmd_nxt = cmd_r;
      if (i_cfg.be[0]) begin
         cmd_nxt[7:0] = i_cfg.wdata[7:0] & bcid_pkg::CMD_WR_MASK[7:0];
      end
      if (i_cfg.be[1]) begin
         cmd_nxt[15:8] = i_cfg.wdata[15:8] & bcid_pkg::CMD_WR_MASK[15:8];
      end
   end

   // takes effect the cycle after the write
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cmd_r <= bcid_pkg::CMD_RESET;
      end else if (i_ce && cmd_wr) begin
         cmd_r <= cmd_nxt;
      end
   end

   // command bits to the rest of the bridge, registered copies
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_legacy_irq_suppress <= 1'b0;
         o_serr_enable         <= 1'b0;
         o_perr_enable         <= 1'b0;
      end else if (i_ce) begin
         o_legacy_irq_suppress <= suppress;
         o_serr_enable         <= serr_en;
         o_perr_enable         <= perr_en;
      end
   end

   // ---------------------------------------------------------
   // status flags
   // ---------------------------------------------------------

   // clear strobes: sse enabled by lane 3, mdpe by lane 2 of dword 1; both data bits sit in lane 3
   assign sse_clr  = cmd_wr && i_cfg.be[3]
                     && i_cfg.wdata[bcid_pkg::STS_WORD_LSB + bcid_pkg::STS_SSE_BIT];
   assign mdpe_clr = cmd_wr && i_cfg.be[2]
                     && i_cfg.wdata[bcid_pkg::STS_WORD_LSB + bcid_pkg::STS_MDPE_BIT];

   // set on the cycle the serr message is handed out; a set
   // in the same cycle as a clear wins so no event is lost
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sts_sse_r <= 1'b0;
      end else if (i_ce) begin
         if (serr_grant) begin
            sts_sse_r <= 1'b1;
         end else if (sse_clr) begin
            sts_sse_r <= 1'b0;
         end
      end
   end

   // parity flag only ever sets while response is enabled
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sts_mdpe_r <= 1'b0;
      end else if (i_ce) begin
         if (i_mstr_parity_err && perr_en) begin
            sts_mdpe_r <= 1'b1;
         end else if (mdpe_clr) begin
            sts_mdpe_r <= 1'b0;
         end
      end
   end

   // status read image, built from the flags
   always_comb begin
      sts_word                         = bcid_pkg::STS_FIXED;
      sts_word[bcid_pkg::STS_SSE_BIT]  = sts_sse_r;
      sts_word[bcid_pkg::STS_MDPE_BIT] = sts_mdpe_r;
   end

   // ---------------------------------------------------------
   // read path
   // ---------------------------------------------------------

   // identification is fixed at build time, no storage
   assign dev_code = {DEV_UPPER, DEV_MIDDLE, DEV_LOWER};

   // unmapped dwords read zero; lanes without enable read too,
   // since nothing here has read side effects
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_id) begin
         rd_mux = {dev_code, VENDOR_CODE};
      end else if (hit_cmd) begin
         rd_mux = {sts_word, cmd_r};
      end
   end

   // every cycle is acknowledged one clock later
   // no wait states: the host never stalls here
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_cfg_ack   <= 1'b0;
         o_cfg_rdata <= 32'h0000_0000;
      end else if (i_ce) begin
         o_cfg_ack <= i_cfg.rd || i_cfg.wr;
         if (i_cfg.rd) begin
            o_cfg_rdata <= rd_mux;
         end
      end
   end

   // ---------------------------------------------------------
   // system error messaging
   // ---------------------------------------------------------

   // either enable source is enough; inputs carry only errors
   // detected on the primary side, secondary receipts stay out
   assign serr_event = ((i_err_nonfatal || i_err_fatal) && serr_en)
                       || (i_err_nonfatal && i_dctl_nonfatal_en)
                       || (i_err_fatal && i_dctl_fatal_en);

   // errors in a burst fold into one pending message
   // an event beside a grant keeps it pending
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         serr_pend_r <= 1'b0;
      end else if (i_ce) begin
         if (serr_event) begin
            serr_pend_r <= 1'b1;
         end else if (serr_grant) begin
            serr_pend_r <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------
   // forwarded interrupt messages
   // ---------------------------------------------------------

   // one-entry slot; suppress is never consulted here
   assign fwd_full_nxt = (fwd_full_r && !fwd_grant)
                         || (i_fwd_intx_valid && o_fwd_intx_ready);

   // ready is registered: a bubble per message, short paths
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fwd_full_r       <= 1'b0;
         o_fwd_intx_ready <= 1'b1;
         fwd_msg_r        <= '0;
      end else if (i_ce) begin
         fwd_full_r       <= fwd_full_nxt;
         o_fwd_intx_ready <= !fwd_full_nxt;
         if (i_fwd_intx_valid && o_fwd_intx_ready) begin
            fwd_msg_r.kind <= i_fwd_intx_assert ? bcid_pkg::BCID_MSG_FWD_ASRT
                                                : bcid_pkg::BCID_MSG_FWD_DASRT;
            fwd_msg_r.line <= i_fwd_intx_line;
         end
      end
   end

   // ---------------------------------------------------------
   // own interrupt and the message arbiter
   // ---------------------------------------------------------

   // suppress only reaches the function's own interrupt
   bcid_own_irq u_own_irq (
      .i_ref_clk    (i_ref_clk),
      .i_rst_n      (i_rst_n),
      .i_ce         (i_ce),
      .i_req        (i_own_irq_req),
      .i_suppress   (suppress),
      .i_grant      (own_grant),
      .o_send       (own_send),
      .o_is_assert  (own_assert),
      .o_asserted_r (o_own_irq_asserted)
   );

   // one registered slot toward the hub
   bcid_msg_arb u_msg_arb (
      .i_ref_clk     (i_ref_clk),
      .i_rst_n       (i_rst_n),
      .i_ce          (i_ce),
      .i_serr_req    (serr_pend_r),
      .i_own_send    (own_send),
      .i_own_assert  (own_assert),
      .i_fwd_valid   (fwd_full_r),
      .i_fwd_msg     (fwd_msg_r),
      .i_msg_ready   (i_msg_ready),
      .o_serr_grant  (serr_grant),
      .o_own_grant   (own_grant),
      .o_fwd_grant   (fwd_grant),
      .o_msg_valid_r (o_msg_valid),
      .o_msg_r       (o_msg)
   );

endmodule

// *** testbench/bcid_hub_model.sv ***
`timescale 1ns/1ps
// hub end of the message link: takes one message per handshake
module bcid_hub_model (
   input  wire logic                i_ref_clk,
   input  wire logic                i_rst_n,
   input  wire logic                i_slow,      // stall every other cycle
   input  wire logic                i_msg_valid,
   input  wire bcid_pkg::bcid_msg_s i_msg,
   output logic                     o_msg_ready,
   output logic [7:0]               o_count,     // messages taken
   output bcid_pkg::bcid_msg_s      o_last       // last message taken
);
   logic tog_r; // stall phase, so slow mode makes the bridge hold its message

   assign o_msg_ready = !i_slow || tog_r;

   // count and record every accepted message
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tog_r   <= 1'b0;
         o_count <= 8'h00;
         o_last  <= '0;
      end else begin
         tog_r <= !tog_r;
         if (i_msg_valid && o_msg_ready) begin
            o_count <= o_count + 8'h01;
            o_last  <= i_msg;
         end
      end
   end
endmodule

// *** testbench/bcid_bridge_cfg_props.sv ***
`timescale 1ns/1ps
// watches the config port and the upstream message stream
module bcid_bridge_cfg_props #(
   parameter logic [15:0] VENDOR_CODE = 16'h5A5A, // arbitrary value
   parameter logic [7:0]  DEV_UPPER   = 8'hC3,    // arbitrary value
   parameter logic [3:0]  DEV_MIDDLE  = 4'h6,     // arbitrary value
   parameter logic [3:0]  DEV_LOWER   = 4'h9      // arbitrary value
) (
   input wire logic                    i_ref_clk,
   input wire logic                    i_rst_n,
   input wire logic                    i_ce,
   input wire bcid_pkg::bcid_cfg_req_s i_cfg,
   input wire logic                    o_cfg_ack,
   input wire logic [31:0]             o_cfg_rdata,
   input wire logic                    o_own_irq_asserted,
   input wire logic                    i_fwd_intx_valid,
   input wire logic                    i_fwd_intx_assert,
   input wire logic [1:0]              i_fwd_intx_line,
   input wire logic                    o_fwd_intx_ready,
   input wire logic                    i_err_fatal,
   input wire logic                    i_dctl_fatal_en,
   input wire logic                    o_msg_valid,
   input wire bcid_pkg::bcid_msg_s     o_msg,
   input wire logic                    i_msg_ready,
   input wire logic                    o_legacy_irq_suppress,
   input wire logic                    o_serr_enable
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   logic                take;      // config cycle taken this edge
   logic                fwd_acc;   // forwarded message accepted this edge
   bcid_pkg::bcid_msg_s fwd_exp_r; // message the forwarded one must become

   assign take    = i_ce && (i_cfg.rd || i_cfg.wr);
   assign fwd_acc = i_ce && i_fwd_intx_valid && o_fwd_intx_ready;

   // remember the accepted forwarded message until it shows upstream
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fwd_exp_r <= '0;
      end else if (fwd_acc) begin
         fwd_exp_r.kind <= i_fwd_intx_assert ? bcid_pkg::BCID_MSG_FWD_ASRT : bcid_pkg::BCID_MSG_FWD_DASRT;
         fwd_exp_r.line <= i_fwd_intx_line;
      end
   end

   ack_follows_a: assert property (o_cfg_ack == $past(take))
      else $error("ack not one cycle after request");
   id_value_a: assert property (take && i_cfg.rd && i_cfg.dw == bcid_pkg::DW_ID
      |=> o_cfg_rdata == {DEV_UPPER, DEV_MIDDLE, DEV_LOWER, VENDOR_CODE}) else $error("id dword wrong");
   cmd_zero_bits_a: assert property (take && i_cfg.rd && i_cfg.dw == bcid_pkg::DW_CMD
      |=> (o_cfg_rdata[15:0] & ~bcid_pkg::CMD_WR_MASK) == 16'h0000) else $error("fixed command bit set");
   cmd_readback_a: assert property (take && i_cfg.rd && i_cfg.dw == bcid_pkg::DW_CMD
      |=> {o_cfg_rdata[10], o_cfg_rdata[8]} == {o_legacy_irq_suppress, o_serr_enable})
      else $error("command read differs from outputs");
   cmd_write_a: assert property (take && i_cfg.wr && i_cfg.dw == bcid_pkg::DW_CMD && i_cfg.be[1]
      |=> ##1 o_legacy_irq_suppress == $past(i_cfg.wdata[10], 2)) else $error("suppress bit not written");
   no_own_assert_a: assert property (o_legacy_irq_suppress && $past(o_legacy_irq_suppress, 2) && o_msg_valid
      && !$past(o_msg_valid) |-> o_msg.kind != bcid_pkg::BCID_MSG_OWN_ASRT) else $error("own assert while suppressed");
   own_release_a: assert property ($rose(o_legacy_irq_suppress) |-> ##[0:20] !o_own_irq_asserted)
      else $error("own interrupt not released");
   fwd_passes_a: assert property (fwd_acc |-> ##[1:12] (o_msg_valid && o_msg == fwd_exp_r))
      else $error("forwarded message lost");
   serr_sent_a: assert property (i_err_fatal && (o_serr_enable || i_dctl_fatal_en)
      |-> ##[1:12] (o_msg_valid && o_msg.kind == bcid_pkg::BCID_MSG_SERR)) else $error("serr message missing");
   msg_hold_a: assert property (o_msg_valid && !i_msg_ready |=> o_msg_valid && $stable(o_msg))
      else $error("message dropped before ready");

   serr_c: cover property (o_msg_valid && o_msg.kind == bcid_pkg::BCID_MSG_SERR);
   own_c: cover property (o_msg_valid && o_msg.kind == bcid_pkg::BCID_MSG_OWN_DASRT);
   fwd_c: cover property (fwd_acc && !i_fwd_intx_assert);
endmodule

// *** testbench/bcid_bridge_cfg_test.sv ***
`timescale 1ns/1ps
// register sequences plus error, interrupt and forwarding traffic
module bcid_bridge_cfg_test;
   localparam logic [15:0] VC = 16'h5A5A; // arbitrary value
   localparam logic [15:0] DC = 16'hC369; // arbitrary value
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   bcid_pkg::bcid_cfg_req_s cfg = '0;
   logic own_req = 1'b0, fwd_v = 1'b0, fwd_a = 1'b0, err_nf = 1'b0, err_f = 1'b0;
   logic dctl_f = 1'b0, dctl_nf = 1'b0, par = 1'b0, slow = 1'b0;
   logic [1:0] fwd_l = 2'h0;
   logic ack, asrt, fwd_rdy, msg_v, msg_rdy, sup, serr_en, perr_en;
   logic [31:0] rdata, rdat;
   bcid_pkg::bcid_msg_s msg, last;
   logic [7:0] cnt, seen = 8'h00;
   int errors = 0, num_checks = 0;

   always #12.5 clk = !clk; // 40 MHz

   bcid_bridge_cfg #(.VENDOR_CODE(VC), .DEV_UPPER(DC[15:8]), .DEV_MIDDLE(DC[7:4]), .DEV_LOWER(DC[3:0]))
   bcid_bridge_cfg_inst (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_cfg(cfg), .o_cfg_ack(ack),
      .o_cfg_rdata(rdata), .i_own_irq_req(own_req), .o_own_irq_asserted(asrt), .i_fwd_intx_valid(fwd_v),
      .i_fwd_intx_assert(fwd_a), .i_fwd_intx_line(fwd_l), .o_fwd_intx_ready(fwd_rdy), .i_err_nonfatal(err_nf),
      .i_err_fatal(err_f), .i_dctl_nonfatal_en(dctl_nf), .i_dctl_fatal_en(dctl_f), .i_mstr_parity_err(par),
      .o_msg_valid(msg_v), .o_msg(msg), .i_msg_ready(msg_rdy), .o_legacy_irq_suppress(sup),
      .o_serr_enable(serr_en), .o_perr_enable(perr_en));

   bcid_hub_model bcid_hub_model_inst (.i_ref_clk(clk), .i_rst_n(rst_n), .i_slow(slow), .i_msg_valid(msg_v),
      .i_msg(msg), .o_msg_ready(msg_rdy), .o_count(cnt), .o_last(last));

   // one comparison, counted; mismatch reported at once
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // one config cycle; ack must come one cycle later, read data kept in rdat
   task automatic op(input logic rd, input logic [9:0] dw, input logic [3:0] be, input logic [31:0] wd);
      @(posedge clk);
      cfg <= '{rd: rd, wr: !rd, dw: dw, be: be, wdata: wd};
      @(posedge clk);
      cfg <= '0;
      #1;
      chk({31'h0, ack}, 32'h1, "ack");
      rdat = rdata;
   endtask

   // wait for the next message at the hub and compare it
   task automatic wait_msg(input bcid_pkg::bcid_msg_kind_e k, input logic [1:0] ln);
      for (int i = 0; i < 40 && cnt === seen; i++) @(posedge clk);
      chk({24'h0, cnt}, {24'h0, seen + 8'h01}, "message count");
      chk({27'h0, last}, {27'h0, k, ln}, "message");
      seen = cnt;
   endtask

   // one-cycle event pulses
   task automatic pulse(input logic f, input logic nf, input logic p);
      @(posedge clk);
      {err_f, err_nf, par} <= {f, nf, p};
      @(posedge clk);
      {err_f, err_nf, par} <= 3'b000;
      repeat (12) @(posedge clk);
   endtask

   // forwarded interrupt message; ready is high whenever the slot is idle
   task automatic fwd(input logic a, input logic [1:0] ln);
      @(posedge clk);
      {fwd_v, fwd_a, fwd_l} <= {1'b1, a, ln};
      @(posedge clk);
      fwd_v <= 1'b0;
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // a hang cuts the run short through the same verdict
   initial begin
      repeat (3000) @(posedge clk);
      errors++;
      give_verdict();
   end

   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      #1 chk({29'h0, ack, msg_v, fwd_rdy}, 32'h1, "reset outputs");
      op(1, 10'h000, 4'h0, 32'h0); chk(rdat, {DC, VC}, "id");
      op(0, 10'h000, 4'hF, 32'hFFFF_FFFF);
      op(1, 10'h000, 4'h0, 32'h0); chk(rdat, {DC, VC}, "id after write");
      op(1, 10'h001, 4'h0, 32'h0); chk(rdat, 32'h0010_0000, "reset cmd");
      op(0, 10'h001, 4'h3, 32'hFFFF_FFFF);
      op(1, 10'h001, 4'h0, 32'h0); chk(rdat, 32'h0010_0540, "cmd ones");
      op(0, 10'h001, 4'h0, 32'h0);
      op(1, 10'h001, 4'h0, 32'h0); chk(rdat, 32'h0010_0540, "no byte enable");
      op(1, 10'h3FF, 4'h0, 32'h0); chk(rdat, 32'h0, "unmapped");
      op(0, 10'h001, 4'h3, 32'h0000_0100);
      pulse(0, 1, 0); wait_msg(bcid_pkg::BCID_MSG_SERR, 2'h0);
      op(1, 10'h001, 4'h0, 32'h0); chk(rdat, 32'h4010_0100, "sse set");
      op(0, 10'h001, 4'h8, 32'h4000_0000);
      op(1, 10'h001, 4'h0, 32'h0); chk(rdat, 32'h0010_0100, "sse cleared");
      op(0, 10'h001, 4'h3, 32'h0);
      pulse(1, 1, 1); chk({24'h0, cnt}, {24'h0, seen}, "serr disabled");
      op(1, 10'h001, 4'h0, 32'h0); chk(rdat, 32'h0010_0000, "mdpe gated");
      @(posedge clk) dctl_f <= 1'b1;
      pulse(1, 0, 0); wait_msg(bcid_pkg::BCID_MSG_SERR, 2'h0);
      @(posedge clk) {dctl_f, dctl_nf} <= 2'b01;
      pulse(0, 1, 0); wait_msg(bcid_pkg::BCID_MSG_SERR, 2'h0);
      op(0, 10'h001, 4'h3, 32'h0000_0040);
      pulse(0, 0, 1);
      op(1, 10'h001, 4'h0, 32'h0); chk(rdat, 32'h4110_0040, "mdpe set");
      chk({29'h0, sup, serr_en, perr_en}, 32'h1, "cmd outputs");
      @(posedge clk) {slow, own_req} <= 2'b11;
      wait_msg(bcid_pkg::BCID_MSG_OWN_ASRT, 2'h0);
      #1 chk({31'h0, asrt}, 32'h1, "own asserted");
      op(0, 10'h001, 4'h3, 32'h0000_0400);
      wait_msg(bcid_pkg::BCID_MSG_OWN_DASRT, 2'h0);
      repeat (2) @(posedge clk);
      #1 chk({31'h0, asrt}, 32'h0, "own released");
      repeat (12) @(posedge clk);
      chk({24'h0, cnt}, {24'h0, seen}, "suppressed");
      fwd(1, 2'h2); wait_msg(bcid_pkg::BCID_MSG_FWD_ASRT, 2'h2);
      fwd(0, 2'h1); wait_msg(bcid_pkg::BCID_MSG_FWD_DASRT, 2'h1);
      give_verdict();
   end
endmodule

bind bcid_bridge_cfg bcid_bridge_cfg_props #(.VENDOR_CODE(VENDOR_CODE), .DEV_UPPER(DEV_UPPER),
   .DEV_MIDDLE(DEV_MIDDLE), .DEV_LOWER(DEV_LOWER)) bcid_bridge_cfg_props_inst (.i_ref_clk, .i_rst_n, .i_ce,
   .i_cfg, .o_cfg_ack, .o_cfg_rdata, .o_own_irq_asserted, .i_fwd_intx_valid, .i_fwd_intx_assert,
   .i_fwd_intx_line, .o_fwd_intx_ready, .i_err_fatal, .i_dctl_fatal_en, .o_msg_valid, .o_msg, .i_msg_ready,
   .o_legacy_irq_suppress, .o_serr_enable);
